// >>> design/fsp_ctrl.sv
// command acceptance, suspend/resume sequencing and software sector protection
// assumes an external array engine that runs, halts and resumes operations
// Notes on behaviour
// - suspend refuses protection, lockdown, security writes
// - register and identification reads always accepted
// - buffer load refused only for suspended buffer
// - buffer compare refused only for suspended buffer
// - power-down commands refused during any suspend
// - hardware and software reset always accepted
// - resume is one opcode, extra bytes ignored
// - resume clears flag, shows busy, restarts
// - program resumes before a pending erase
// - suspend ignored while resume still settling
// - enable sequence sets protection at frame end
// - disable sequence clears protection at frame end
// - enabled protection blocks marked sectors
// - software protection cleared at power-up
// - floating write-protect reads inactive, software only
// - status shows protection from either method
// - suspend halts operation, sets flag, ready
// - disable ignored while write-protect asserted
`timescale 1ns/100ps
module fsp_ctrl
   import fsp_pkg::*;
#(
   // opcodes of commands judged here but not printed with this block
   parameter logic [7:0] OP_RD_SPR = 8'h11,
   parameter logic [7:0] OP_RD_LOCK = 8'h12,
   parameter logic [7:0] OP_RD_SEC = 8'h13,
   parameter logic [7:0] OP_RD_CFG = 8'h14,
   parameter logic [7:0] OP_RD_STAT = 8'h15,
   parameter logic [7:0] OP_RD_ID = 8'h16,
   parameter logic [7:0] OP_XFER_B1 = 8'h17,
   parameter logic [7:0] OP_XFER_B2 = 8'h18,
   parameter logic [7:0] OP_CMP_B1 = 8'h19,
   parameter logic [7:0] OP_CMP_B2 = 8'h1A,
   parameter logic [7:0] OP_DPD_ENTER = 8'h1B,
   parameter logic [7:0] OP_DPD_EXIT = 8'h1C,
   parameter logic [7:0] OP_UDPD_ENTER = 8'h1D,
   parameter logic [7:0] OP_SW_RESET = 8'h1E,
   parameter logic [7:0] OP_SEC_PROG = 8'h1F,
   parameter logic [7:0] LOCK_LAST = 8'h21,
   parameter logic [7:0] FREEZE_LAST = 8'h22,
   parameter logic [7:0] SPR_PROG_LAST = 8'h23
) (
   // core clock and power-on reset
   input wire logic clk,
   input wire logic nrst,
   // serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   // write-protect pin, pulled up in the pad
   input wire logic wp_n,
   // hardware reset pin
   input wire logic reset_n,
   // array engine
   input fsp_opk_t op_kind,
   input wire logic op_done,
   input wire logic sector_marked,
   output logic op_halt,
   output logic op_resume,
   output fsp_opk_t op_resume_kind,
   output logic op_blocked,
   // verdict and status
   output fsp_verdict_t verdict,
   output fsp_status_t status,
   output logic reset_req
);

   // sequencing states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_RESUMING = 3'b100
   } fsp_state_t;

   // link frame and sequencing state
   fsp_frame_t frame;
   fsp_state_t st_q, st_d;
   // pin synchroniser stages
   logic cs_s1_q, cs_s2_q, cs_s3_q;
   logic wp_s1_q, wp_s2_q;
   logic rst_s1_q, rst_s2_q, rst_s3_q;
   // suspend flags, protection and the operation in flight
   logic ps1_q, ps2_q, es_q;
   logic sw_prot_q;
   fsp_opk_t run_q;
   logic [RES_CNT_W-1:0] res_cnt_q;
   // registered outputs
   fsp_verdict_t verdict_q;
   logic halt_q, resume_q, reset_q;
   fsp_opk_t resume_kind_q;

   // single-opcode match: one full byte is enough, later bytes are ignored
   function automatic logic op_is(input fsp_frame_t f, input logic [7:0] code);
      return (f.count >= CNT_ONE) && (f.b0 == code);
   endfunction : op_is

   // protection-family match: whole three-byte prefix plus the given last byte
   function automatic logic prot_is(input fsp_frame_t f, input logic [7:0] last);
      return (f.count >= CNT_FOUR) && (f.b0 == OP_PROT_B1) && (f.b1 == OP_PROT_B2)
         && (f.b2 == OP_PROT_B3) && (f.b3 == last);
   endfunction : prot_is

   // a load or compare clashes only with the buffer whose program is parked
   function automatic logic buf_clash(input logic hit_b1, input logic hit_b2,
                                      input logic s1, input logic s2);
      return (hit_b1 & s1) | (hit_b2 & s2);
   endfunction : buf_clash

   // receiver on the link clock
   fsp_link_rx u_rx (
      .sclk(sclk),
      .cs_n(cs_n),
      .mosi(mosi),
      .frame(frame)
   );

   // pin synchronisers; the frame bytes are read only after cs_n is seen high,
   // when the link clock is idle and they cannot change
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
      end else begin
         cs_s1_q <= cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
      end
   end

   // write-protect synchroniser, reset to the pulled-up level
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wp_s1_q <= 1'b1;
         wp_s2_q <= 1'b1;
      end else begin
         wp_s1_q <= wp_n;
         wp_s2_q <= wp_s1_q;
      end
   end

   // reset pin synchroniser with an edge stage; idle high so no false edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= 1'b1;
         rst_s3_q <= 1'b1;
      end else begin
         rst_s1_q <= reset_n;
         rst_s2_q <= rst_s1_q;
         rst_s3_q <= rst_s2_q;
      end
   end

   // frame end and reset pin events
   wire logic frame_end = cs_s2_q & ~cs_s3_q;
   wire logic pin_reset = ~rst_s2_q & rst_s3_q;
   wire logic wp_asserted = ~wp_s2_q;
   // a floating pin pulls high, leaving only the software state in force
   wire logic prot_on = sw_prot_q | wp_asserted;

   // frame decode; the bytes are quasi-static here because the link clock
   // stands still while cs_n is high
   wire logic [7:0] opc = frame.b0;
   wire logic is_prot_en = prot_is(frame, OP_PROT_EN);
   wire logic is_prot_dis = prot_is(frame, OP_PROT_DIS);
   wire logic is_spr_erase = prot_is(frame, OP_SPR_ERASE);
   wire logic is_spr_prog = prot_is(frame, SPR_PROG_LAST);
   wire logic is_lock = prot_is(frame, LOCK_LAST);
   wire logic is_freeze = prot_is(frame, FREEZE_LAST);
   // extra bytes after these single opcodes are ignored
   wire logic is_resume = op_is(frame, OP_RESUME);
   wire logic is_suspend = op_is(frame, OP_SUSPEND);
   wire logic is_reset = op_is(frame, OP_SW_RESET);
   // single opcodes that a suspend can refuse
   wire logic is_sec_prog = op_is(frame, OP_SEC_PROG);
   wire logic is_xfer_b1 = op_is(frame, OP_XFER_B1);
   wire logic is_xfer_b2 = op_is(frame, OP_XFER_B2);
   wire logic is_cmp_b1 = op_is(frame, OP_CMP_B1);
   wire logic is_cmp_b2 = op_is(frame, OP_CMP_B2);
   wire logic is_dpd_enter = op_is(frame, OP_DPD_ENTER);
   wire logic is_dpd_exit = op_is(frame, OP_DPD_EXIT);
   wire logic is_udpd_enter = op_is(frame, OP_UDPD_ENTER);

   // suspend state summary
   wire logic any_susp = ps1_q | ps2_q | es_q;
   wire logic resuming = (st_q == ST_RESUMING);

   // refusal classes
   wire logic prot_family = is_prot_en | is_prot_dis | is_spr_erase | is_spr_prog
      | is_lock | is_freeze | is_sec_prog;
   wire logic ref_protcmd = any_susp & prot_family;
   wire logic ref_xfer = buf_clash(is_xfer_b1, is_xfer_b2, ps1_q, ps2_q);
   wire logic ref_cmp = buf_clash(is_cmp_b1, is_cmp_b2, ps1_q, ps2_q);
   wire logic power_down = is_dpd_enter | is_dpd_exit | is_udpd_enter;
   wire logic ref_pd = any_susp & power_down;
   // reads never fall in a refusal class, and reset is kept out of all of them
   wire logic refused = ~is_reset & (ref_protcmd | ref_xfer | ref_cmp | ref_pd);

   // suspend and resume qualification
   wire logic do_suspend = frame_end && is_suspend && st_q == ST_RUN;
   wire logic resume_prog = ps1_q | ps2_q;
   // a resume with nothing parked, or while busy, is taken but does nothing
   wire logic do_resume = frame_end && is_resume && any_susp && st_q == ST_IDLE;
   wire logic do_reset = pin_reset | (frame_end && is_reset);
   wire logic take_prot = frame_end && !refused;
   fsp_opk_t resume_target;
   assign resume_target = ps1_q ? OPK_PROG_B1 : (ps2_q ? OPK_PROG_B2 : OPK_ERASE);

   // sequencing state
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE: begin
            if (do_resume) st_d = ST_RESUMING;
            else if (op_kind != OPK_NONE) st_d = ST_RUN;
         end
         ST_RUN: begin
            if (do_suspend || op_done) st_d = ST_IDLE;
         end
         ST_RESUMING: begin
            if (res_cnt_q == RES_CNT_ZERO) st_d = ST_RUN;
         end
         default: st_d = ST_IDLE;
      endcase
      // a reset aborts whatever is running or parked
      if (do_reset) st_d = ST_IDLE;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) st_q <= ST_IDLE;
      else st_q <= st_d;
   end

   // resume settling time; suspends seen during it are dropped
   // limitation: a fixed count from the chosen latency, not a measured one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) res_cnt_q <= RES_CNT_ZERO;
      else if (do_resume) res_cnt_q <= RES_CNT_LOAD;
      else if (resuming && res_cnt_q != RES_CNT_ZERO) res_cnt_q <= res_cnt_q - 1'b1;
   end

   // operation being run, tracked for the suspend target
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) run_q <= OPK_NONE;
      else if (do_reset || do_suspend || (op_done && st_q == ST_RUN)) run_q <= OPK_NONE;
      else if (do_resume) run_q <= resume_target;
      else if (st_q == ST_IDLE && op_kind != OPK_NONE) run_q <= op_kind;
   end

   // suspend flags: a program suspend during erase suspend sets both
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ps1_q <= 1'b0;
         ps2_q <= 1'b0;
         es_q <= 1'b0;
      end else if (do_reset) begin
         ps1_q <= 1'b0;
         ps2_q <= 1'b0;
         es_q <= 1'b0;
      end else if (do_suspend) begin
         if (run_q == OPK_PROG_B1) ps1_q <= 1'b1;
         if (run_q == OPK_PROG_B2) ps2_q <= 1'b1;
         if (run_q == OPK_ERASE) es_q <= 1'b1;
      end else if (do_resume) begin
         // erase flag stays set until a later resume after the program ends
         if (resume_prog) begin
            ps1_q <= 1'b0;
            ps2_q <= 1'b0;
         end else begin
            es_q <= 1'b0;
         end
      end
   end

   // software protection: volatile, lost on power-on reset
   // enable is taken even with write-protect low; it latches the software state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) sw_prot_q <= 1'b0;
      else if (take_prot && is_prot_en) sw_prot_q <= 1'b1;
      else if (take_prot && is_prot_dis && !wp_asserted) sw_prot_q <= 1'b0;
   end

   // command verdict, one cycle per frame; refusal touches nothing else
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         verdict_q <= '0;
      end else begin
         verdict_q.accepted <= frame_end && !refused;
         verdict_q.refused <= frame_end && refused;
         if (frame_end) begin
            verdict_q.opcode <= opc;
            verdict_q.last_byte <= frame.b3;
         end
      end
   end

   // suspend strobe to the engine
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) halt_q <= 1'b0;
      else halt_q <= do_suspend;
   end

   // resume strobe and the target it names, held for the engine
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         resume_q <= 1'b0;
         resume_kind_q <= OPK_NONE;
      end else begin
         resume_q <= do_resume;
         if (do_resume) resume_kind_q <= resume_target;
      end
   end

   // reset request, from the pin or the command
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) reset_q <= 1'b0;
      else reset_q <= do_reset;
   end

   // program and erase to marked sectors blocked while protection is on
   // the pin only adds protection, it never lifts the software state
   assign op_blocked = prot_on & sector_marked;

   assign op_halt = halt_q;
   assign op_resume = resume_q;
   assign op_resume_kind = resume_kind_q;
   assign reset_req = reset_q;
   assign verdict = verdict_q;
   // busy from the registered state, so a decode glitch never reaches it
   wire logic busy_w = (st_q != ST_IDLE);
   // ready once halted; busy while running or resuming
   assign status = '{busy: busy_w,
                     buf1_program_suspended: ps1_q,
                     buf2_program_suspended: ps2_q,
                     erase_suspended: es_q,
                     prot_enabled: prot_on};

endmodule : fsp_ctrl

// >>> design/fsp_pkg.sv
// shared constants and carrier types for the suspend/resume/protect controller
// assumes a 50 MHz core clock and a mode 0/3 serial link with its own clock
package fsp_pkg;

   // core clock and timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int RESUME_LATENCY_NS = 20000;
   localparam int RESUME_CYC_RAW = RESUME_LATENCY_NS / CLK_PERIOD_NS;
   localparam int RESUME_CYC = (RESUME_CYC_RAW < 1) ? 1 : RESUME_CYC_RAW;
   localparam int RES_CNT_W = $clog2(RESUME_CYC + 1);
   localparam logic [RES_CNT_W-1:0] RES_CNT_LOAD = RES_CNT_W'(RESUME_CYC);
   localparam logic [RES_CNT_W-1:0] RES_CNT_ZERO = '0;

   // frame geometry
   localparam int FRAME_BYTES = 4;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] CNT_SAT = 3'h4;
   localparam logic [2:0] CNT_ONE = 3'h1;
   localparam logic [2:0] CNT_FOUR = 3'h4;

   // opcodes printed for this block
   localparam logic [7:0] OP_SUSPEND = 8'hB0;
   localparam logic [7:0] OP_RESUME = 8'hD0;
   localparam logic [7:0] OP_PROT_B1 = 8'h3D;
   localparam logic [7:0] OP_PROT_B2 = 8'h2A;
   localparam logic [7:0] OP_PROT_B3 = 8'h7F;
   localparam logic [7:0] OP_PROT_EN = 8'hA9;
   localparam logic [7:0] OP_PROT_DIS = 8'h9A;
   localparam logic [7:0] OP_SPR_ERASE = 8'hCF;

   // array operation kinds owned by the external engine
   typedef enum logic [1:0] {
      OPK_NONE = 2'h0,
      OPK_PROG_B1 = 2'h1,
      OPK_PROG_B2 = 2'h2,
      OPK_ERASE = 2'h3
   } fsp_opk_t;

   // bytes captured in one chip-select frame
   typedef struct packed {
      logic [7:0] b0;
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [2:0] count;
   } fsp_frame_t;

   // command verdict handed to the rest of the device
   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] last_byte;
      logic accepted;
      logic refused;
   } fsp_verdict_t;

   // suspend and protection status
   typedef struct packed {
      logic busy;
      logic buf1_program_suspended;
      logic buf2_program_suspended;
      logic erase_suspended;
      logic prot_enabled;
   } fsp_status_t;

endpackage : fsp_pkg

// >>> design/fsp_link_rx.sv
// serial receiver on the link clock: gathers the first four bytes of a frame
// assumes sclk is still outside frames and cs_n high resets the bit count
`timescale 1ns/100ps
module fsp_link_rx
   import fsp_pkg::*;
(
   // link pins
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic mosi,
   // captured frame, stable once cs_n rises
   output fsp_frame_t frame
);

   logic [2:0] bit_q;
   logic [6:0] shift_q;
   logic [2:0] cnt_q;
   logic fresh_q;
   logic [7:0] b0_q, b1_q, b2_q, b3_q;
   wire logic [7:0] byte_w = {shift_q, mosi};
   wire logic byte_end = (bit_q == BIT_LAST);

   // bit counter and first-edge mark restart with every frame
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         bit_q <= '0;
         fresh_q <= 1'b1;
      end else begin
         bit_q <= bit_q + 3'h1;
         fresh_q <= 1'b0;
      end
   end

   // byte count cleared on the first edge, not by cs_n, so the core
   // still reads the finished frame's count after cs_n rises
   always_ff @(posedge sclk) begin
      if (fresh_q) cnt_q <= '0;
      else if (byte_end && cnt_q != CNT_SAT) cnt_q <= cnt_q + 3'h1;
   end

   // data regs keep their value after the frame so the core can read them
   always_ff @(posedge sclk) begin
      shift_q <= byte_w[6:0];
      if (byte_end) begin
         case (cnt_q)
            3'h0: b0_q <= byte_w;
            3'h1: b1_q <= byte_w;
            3'h2: b2_q <= byte_w;
            3'h3: b3_q <= byte_w;
            default: ;
         endcase
      end
   end

   assign frame = '{b0: b0_q, b1: b1_q, b2: b2_q, b3: b3_q, count: cnt_q};

endmodule : fsp_link_rx

// >>> verification/fsp_host.sv
// host model: frames opcode bytes onto the serial link, msb first
// assumes the bench leaves time for the core to see each frame end
`timescale 1ns/100ps
module fsp_host (
   // link pins
   output logic sclk,
   output logic cs_n,
   output logic mosi
);
   // link idles deselected with the clock low
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      mosi = 1'h1;
   end
   // data changes while the clock is low; clock stands still outside frames
   task send(input logic [7:0] q[$]);
      #7;
      cs_n = 1'h0;
      foreach (q[i]) for (int b = 7; b >= 0; b--) begin
         mosi = q[i][b];
         #62.5 sclk = 1'h1;
         #62.5 sclk = 1'h0;
      end
      #30 cs_n = 1'h1;
      mosi = ~mosi; // released line must not keep the last bit
   endtask : send
endmodule : fsp_host

// >>> verification/fsp_ctrl_sva.sv
// checker for the suspend/resume/protect controller, bound to its top
// assumes one core clock domain and the async power-on reset
`timescale 1ns/100ps
module fsp_ctrl_sva
   import fsp_pkg::*;
(
   // clock, reset, pins
   input wire logic clk,
   input wire logic nrst,
   input wire logic wp_n,
   input wire logic reset_n,
   input wire logic sector_marked,
   // outputs watched
   input wire logic op_halt,
   input wire logic op_resume,
   input fsp_opk_t op_resume_kind,
   input wire logic op_blocked,
   input fsp_verdict_t verdict,
   input fsp_status_t status,
   input wire logic reset_req
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   wire logic [2:0] flags = {status.buf1_program_suspended, status.buf2_program_suspended,
      status.erase_suspended};
   wire logic wp_calm = wp_n;
   int unsigned since_res_q;
   // cycles since the last resume, saturating; a halt sooner is a fault
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) since_res_q <= RESUME_CYC;
      else if (op_resume) since_res_q <= 0;
      else if (since_res_q < RESUME_CYC) since_res_q <= since_res_q + 1;
   end
   sequence prot_on_s;
      verdict.accepted && verdict.opcode == OP_PROT_B1 && verdict.last_byte == OP_PROT_EN;
   endsequence
   sequence prot_off_s;
      verdict.accepted && verdict.opcode == OP_PROT_B1 && verdict.last_byte == OP_PROT_DIS
         && wp_calm && $past(wp_calm, 3);
   endsequence
   refuse_keep_a: assert property (verdict.refused |-> !verdict.accepted && !op_halt
      && !op_resume && $stable(flags)) else $error("refused command changed state");
   halt_flag_a: assert property (op_halt |-> !status.busy && flags != 3'h0)
      else $error("halt without flag or ready");
   resume_busy_a: assert property (op_resume |-> status.busy && op_resume_kind != OPK_NONE)
      else $error("resume without busy");
   prog_first_a: assert property (op_resume && $past(status.erase_suspended)
      && $past(flags[2:1]) != 2'h0 |-> op_resume_kind != OPK_ERASE && status.erase_suspended)
      else $error("erase resumed before program");
   halt_gap_a: assert property (op_halt |-> since_res_q + 8 > RESUME_CYC)
      else $error("suspend honoured while resuming");
   hw_reset_a: assert property ($fell(reset_n) |-> ##[1:8] reset_req)
      else $error("reset pin not honoured");
   prot_on_a: assert property (prot_on_s |-> ##[0:1] status.prot_enabled)
      else $error("protection not enabled");
   prot_off_a: assert property (prot_off_s |-> ##[0:1] !status.prot_enabled)
      else $error("protection not disabled");
   blocked_a: assert property (sector_marked && status.prot_enabled && wp_n
      && $past(wp_n, 3) |-> op_blocked) else $error("marked sector not blocked");
endmodule : fsp_ctrl_sva
bind fsp_ctrl fsp_ctrl_sva u_sva (.clk(clk), .nrst(nrst), .wp_n(wp_n), .reset_n(reset_n),
   .sector_marked(sector_marked), .op_halt(op_halt), .op_resume(op_resume),
   .op_resume_kind(op_resume_kind), .op_blocked(op_blocked), .verdict(verdict),
   .status(status), .reset_req(reset_req));

// >>> verification/fsp_ctrl_bench.sv
// self-checking bench for the suspend/resume/protect controller
// assumes the host model drives the link; the bench plays the array engine
`timescale 1ns/100ps
module fsp_ctrl_bench
   import fsp_pkg::*;
;
   logic clk, nrst, sclk, cs_n, mosi, wp_n, reset_n, op_done, sector_marked;
   logic op_halt, op_resume, op_blocked, reset_req, acc_s, ref_s, halt_s, res_s, rr_s;
   fsp_opk_t op_kind, op_resume_kind;
   fsp_verdict_t verdict;
   fsp_status_t status;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [7:0] rf4[6] = '{8'hA9, 8'h9A, 8'hCF, 8'h23, 8'h21, 8'h22};
   logic [7:0] rf1[6] = '{8'h1F, 8'h1B, 8'h1C, 8'h1D, 8'h17, 8'h19};
   logic [7:0] ok1[8] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h1A};
   fsp_ctrl DUT (.clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n),
      .reset_n(reset_n), .op_kind(op_kind), .op_done(op_done), .sector_marked(sector_marked),
      .op_halt(op_halt), .op_resume(op_resume), .op_resume_kind(op_resume_kind),
      .op_blocked(op_blocked), .verdict(verdict), .status(status), .reset_req(reset_req));
   fsp_host host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi));
   // core clock
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   // catch one-cycle pulses; the cycle ceiling cuts a hang short
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (verdict.accepted === 1'h1) acc_s <= 1'h1;
      if (verdict.refused === 1'h1) ref_s <= 1'h1;
      if (op_halt === 1'h1) halt_s <= 1'h1;
      if (op_resume === 1'h1) res_s <= 1'h1;
      if (reset_req === 1'h1) rr_s <= 1'h1;
      if (cyc == 30000) begin
         err_count++;
         summarize();
      end
   end
   task summarize();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   task chk(input logic g, input logic e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task chkk(input fsp_opk_t g, input fsp_opk_t e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chkk
   task chkb(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chkb
   task clks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : clks
   // one frame, then enough cycles for the verdict and the idle gap
   task frame(input logic [7:0] q[$]);
      {acc_s, ref_s, halt_s, res_s, rr_s} = 5'h00;
      host.send(q);
      clks(10);
   endtask : frame
   task cmd(input logic [7:0] q[$], input logic a);
      frame(q);
      chk(acc_s, a);
      chk(ref_s, !a);
   endtask : cmd
   task start(input fsp_opk_t k);
      op_kind = k;
      clks(2);
      op_kind = OPK_NONE;
      clks(2);
   endtask : start
   task finish_op();
      clks(1000);
      op_done = 1'h1;
      clks(1);
      op_done = 1'h0;
      clks(2);
   endtask : finish_op
   initial begin
      nrst = 1'h0;
      wp_n = 1'h1;
      reset_n = 1'h1;
      op_kind = OPK_NONE;
      op_done = 1'h0;
      sector_marked = 1'h1;
      clks(3);
      nrst = 1'h1;
      clks(4);
      chk(status.prot_enabled, 1'h0);
      cmd('{8'h3D, 8'h2A, 8'h7F, 8'hA9}, 1'h1);
      chk(status.prot_enabled, 1'h1);
      chkb(verdict.opcode, 8'h3D);
      chkb(verdict.last_byte, 8'hA9);
      chk(op_blocked, 1'h1);
      wp_n = 1'h0;
      cmd('{8'h3D, 8'h2A, 8'h7F, 8'h9A}, 1'h1);
      chk(status.prot_enabled, 1'h1);
      wp_n = 1'h1;
      cmd('{8'h3D, 8'h2A, 8'h7F, 8'h9A}, 1'h1);
      chk(status.prot_enabled, 1'h0);
      wp_n = 1'h0;
      clks(5);
      chk(status.prot_enabled, 1'h1);
      sector_marked = 1'h0;
      clks(1);
      chk(op_blocked, 1'h0);
      sector_marked = 1'h1;
      wp_n = 1'h1;
      clks(5);
      $display("test protect done");
      start(OPK_PROG_B1);
      cmd('{8'hB0}, 1'h1);
      chk(halt_s, 1'h1);
      chk(status.buf1_program_suspended, 1'h1);
      chk(status.busy, 1'h0);
      foreach (rf4[i]) cmd('{8'h3D, 8'h2A, 8'h7F, rf4[i]}, 1'h0);
      foreach (rf1[i]) cmd('{rf1[i]}, 1'h0);
      chk(status.buf1_program_suspended, 1'h1);
      chk(status.prot_enabled, 1'h0);
      foreach (ok1[i]) cmd('{ok1[i]}, 1'h1);
      $display("test suspend table done");
      cmd('{8'hD0, 8'h55}, 1'h1);
      chk(res_s, 1'h1);
      chkb(verdict.opcode, 8'hD0);
      chkk(op_resume_kind, OPK_PROG_B1);
      chk(status.buf1_program_suspended, 1'h0);
      chk(status.busy, 1'h1);
      frame('{8'hB0});
      chk(halt_s, 1'h0);
      clks(1000);
      cmd('{8'hB0}, 1'h1);
      chk(halt_s, 1'h1);
      $display("test resume done");
      cmd('{8'hD0}, 1'h1);
      finish_op();
      start(OPK_ERASE);
      cmd('{8'hB0}, 1'h1);
      start(OPK_PROG_B2);
      cmd('{8'hB0}, 1'h1);
      chk(status.buf2_program_suspended, 1'h1);
      cmd('{8'hD0}, 1'h1);
      chkk(op_resume_kind, OPK_PROG_B2);
      chk(status.erase_suspended, 1'h1);
      finish_op();
      cmd('{8'h1C}, 1'h0);
      cmd('{8'h17}, 1'h1);
      cmd('{8'hD0}, 1'h1);
      chkk(op_resume_kind, OPK_ERASE);
      chk(status.erase_suspended, 1'h0);
      clks(1000);
      cmd('{8'hB0}, 1'h1);
      cmd('{8'h1E}, 1'h1);
      chk(rr_s, 1'h1);
      rr_s = 1'h0;
      reset_n = 1'h0;
      clks(4);
      reset_n = 1'h1;
      clks(6);
      chk(rr_s, 1'h1);
      $display("test nested and reset done");
      summarize();
   end
endmodule : fsp_ctrl_bench
